// [rtl/ecfg_pkg.sv]
/*
 * Constants for the configuration register logic of one switch port:
 * register offsets, writable masks, reset values and status bit positions.
 * Assumes configuration requests address whole dwords within a 4 KB space.
 */
package ecfg_pkg;

    //**********************************************************
    // Register byte offsets
    //**********************************************************
    localparam logic [11:0] OFF_ADDR = 12'h0F8;
    localparam logic [11:0] OFF_DATA = 12'h0FC;
    localparam logic [11:0] OFF_CAP  = 12'h100;
    localparam logic [11:0] OFF_UES  = 12'h104;

    //**********************************************************
    // Writable masks and reset values
    //**********************************************************
    localparam logic [31:0] ADDR_RW_MASK = 32'h0000_0FFC;
    localparam logic [31:0] ADDR_RST     = 32'h0000_0000;
    localparam logic [31:0] UES_W1C_MASK = 32'h001F_3031;
    localparam logic [31:0] UES_RST      = 32'h0000_0000;
    localparam logic [31:0] DATA_RST     = 32'h0000_0000;

    //**********************************************************
    // Capability header fields
    //**********************************************************
    localparam logic [15:0] CAP_ID_VAL   = 16'h0001;
    localparam logic [3:0]  CAP_VER_VAL  = 4'h1;
    localparam logic [11:0] NEXT_PTR_RST = 12'h180;
    localparam int          CAP_VER_LSB  = 16;
    localparam int          NEXT_PTR_LSB = 20;

    //**********************************************************
    // Uncorrectable error status bit positions
    //**********************************************************
    localparam int UES_WIDTH     = 21;
    localparam int UES_OBSOLETE  = 0;
    localparam int UES_LINK_PROT = 4;
    localparam int UES_SURPRISE  = 5;
    localparam int UES_POISONED  = 12;
    localparam int UES_FC_PROT   = 13;
    localparam int UES_COMP_TO   = 14;
    localparam int UES_COMP_ABT  = 15;
    localparam int UES_UNEXP_CPL = 16;
    localparam int UES_RX_OVF    = 17;
    localparam int UES_MALFORMED = 18;
    localparam int UES_ECRC      = 19;
    localparam int UES_UNSUP_REQ = 20;

endpackage

// [rtl/sticky_w1c_bits.sv]
/*
 * Sticky write-one-to-clear status bits, one flop per bit set in IMPL; other bits read zero.
 * Assumes set and clear vectors come from logic on the same clock.
 */
`timescale 1ns/1ps

module sticky_w1c_bits #(
    parameter int          WIDTH = 21,
    parameter logic [31:0] IMPL  = 32'h001F_3031
) (
    // Clock and fundamental reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Per-bit set and clear strobes
    input  wire logic [WIDTH-1:0] set_vec,
    input  wire logic [WIDTH-1:0] clr_vec,
    // Stored status
    output logic      [WIDTH-1:0] stat_q
);

    //**********************************************************
    // Status flops
    //**********************************************************
    // Only the fundamental reset clears; a set beats a clear
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        if (IMPL[i]) begin : g_impl
            logic bit_q;

            // Own flop per bit keeps one kind of driver on stat_q
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    bit_q <= 1'b0;
                end else if (set_vec[i]) begin
                    bit_q <= 1'b1;
                end else if (clr_vec[i]) begin
                    bit_q <= 1'b0;
                end
            end

            assign stat_q[i] = bit_q;
        end else begin : g_zero
            assign stat_q[i] = 1'b0;
        end
    end

endmodule

// [rtl/aer_cap_header.sv]
/*
 * Error reporting capability header: fixed identifier and version
 * plus a lockable next pointer.
 * Assumes write strobes and byte masks are decoded by the caller.
 */
`timescale 1ns/1ps

module aer_cap_header (
    // Clock and resets
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        hot_reset,
    // Write side
    input  wire logic        wr_en,
    input  wire logic        write_lock,
    input  wire logic [31:0] wr_mask,
    input  wire logic [31:0] wr_data,
    // Header word
    output logic      [31:0] header
);
    import ecfg_pkg::*;

    logic [11:0] next_ptr_q;
    logic [11:0] next_ptr_d;
    logic [11:0] ptr_mask;
    logic [11:0] ptr_wdata;

    //**********************************************************
    // Next pointer, writable only while unlocked
    //**********************************************************
    assign ptr_mask   = wr_mask[31:NEXT_PTR_LSB];
    assign ptr_wdata  = wr_data[31:NEXT_PTR_LSB];
    assign next_ptr_d = (next_ptr_q & ~ptr_mask) | (ptr_wdata & ptr_mask);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            next_ptr_q <= NEXT_PTR_RST;
        end else if (hot_reset) begin
            next_ptr_q <= NEXT_PTR_RST;
        end else if (wr_en && !write_lock) begin
            next_ptr_q <= next_ptr_d;
        end
    end

    // Identifier and version are constants
    assign header = {next_ptr_q, CAP_VER_VAL, CAP_ID_VAL};

endmodule

// [rtl/ecfg_regs.sv]
/*
 * Configuration register logic of one switch port: the indirect
 * address and data window, the error reporting capability header and
 * the uncorrectable error status register.
 * Assumes one configuration request port, shared by in-band requests
 * and the side-band management bus, with a flag telling them apart.
 * Error events are one-cycle pulses from logic on the same clock.
 */
`timescale 1ns/1ps

module ecfg_regs (
    // Clock and resets
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        hot_reset,

    // Configuration request port
    input  wire logic        cfg_req,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_sideband,
    input  wire logic [11:2] cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    output logic             cfg_ack,

    // Static controls
    input  wire logic        cfg_write_lock,
    input  wire logic        surprise_down_report_capable,

    // Error events, one-cycle pulses
    input  wire logic        link_protocol_error,
    input  wire logic        surprise_link_down_error,
    input  wire logic        poisoned_tlp,
    input  wire logic        flow_credit_protocol_error,
    input  wire logic        unexpected_completion,
    input  wire logic        receive_overflow,
    input  wire logic        malformed_tlp,
    input  wire logic        ecrc_error,
    input  wire logic        unsupported_request,

    // State views
    output logic      [31:0] indirect_config_address,
    output logic      [31:0] uncorrectable_error_status
);
    import ecfg_pkg::*;

    //**********************************************************
    // Declarations
    //**********************************************************
    logic [31:0]          addr_q;
    logic [31:0]          addr_d;
    logic [31:0]          rdata_q;
    logic [31:0]          rdata_d;
    logic                 ack_q;

    logic [31:0]          byte_mask;
    logic                 data_hit;
    logic                 indirect;
    logic                 self_point;
    logic                 dead;
    logic [11:2]          sel_idx;
    logic                 req_wr;
    logic                 req_rd;

    logic                 sel_addr;
    logic                 sel_cap;
    logic                 sel_ues;
    logic                 wr_addr;
    logic                 wr_cap;
    logic                 wr_ues;

    logic [31:0]          cap_word;
    logic [31:0]          ues_word;
    logic [31:0]          mux_word;
    logic [UES_WIDTH-1:0] ues_q;
    logic [UES_WIDTH-1:0] ues_set;
    logic [UES_WIDTH-1:0] ues_clr;
    logic [UES_WIDTH-1:0] ues_wclr;
    logic [UES_WIDTH-1:0] ues_force;

    //**********************************************************
    // Byte enables
    //**********************************************************
    // Expand the byte enables of the access into a bit mask
    for (genvar b = 0; b < 4; b++) begin : g_be
        assign byte_mask[8*b +: 8] = {8{cfg_be[b]}};
    end

    //**********************************************************
    // Window decode
    //**********************************************************
    // Access aimed at the data window
    assign data_hit = (cfg_addr == OFF_DATA[11:2]);

    // In-band window access is redirected through the address register
    assign indirect = data_hit && !cfg_sideband;

    // Window pointing back at itself
    assign self_point = (addr_q[11:2] == OFF_DATA[11:2]);

    // Window accesses that read zero and drop writes
    assign dead = data_hit && (cfg_sideband || self_point);

    // Register number and extended number form the target index
    assign sel_idx = indirect ? addr_q[11:2] : cfg_addr;

    // Request qualifiers
    assign req_wr = cfg_req && cfg_wr && !dead;
    assign req_rd = cfg_req && !cfg_wr;

    //**********************************************************
    // Target select
    //**********************************************************
    // Pointing at the address register lands writes there
    assign sel_addr = (sel_idx == OFF_ADDR[11:2]);
    assign sel_cap  = (sel_idx == OFF_CAP[11:2]);
    assign sel_ues  = (sel_idx == OFF_UES[11:2]);

    // Write strobes for each target
    assign wr_addr = req_wr && sel_addr;
    assign wr_cap  = req_wr && sel_cap;
    assign wr_ues  = req_wr && sel_ues;

    //**********************************************************
    // Indirect address register
    //**********************************************************
    // Merge the enabled bytes, keep reserved bits at zero
    assign addr_d = ((addr_q & ~byte_mask) | (cfg_wdata & byte_mask))
                    & ADDR_RW_MASK;

    // Cleared by either reset, updated on a selected write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            addr_q <= ADDR_RST;
        end else if (hot_reset) begin
            addr_q <= ADDR_RST;
        end else if (wr_addr) begin
            addr_q <= addr_d;
        end
    end

    assign indirect_config_address = addr_q;

    //**********************************************************
    // Capability header
    //**********************************************************
    aer_cap_header u_cap (
        .clk        (clk),
        .nrst       (nrst),
        .hot_reset  (hot_reset),
        .wr_en      (wr_cap),
        .write_lock (cfg_write_lock),
        .wr_mask    (byte_mask),
        .wr_data    (cfg_wdata),
        .header     (cap_word)
    );

    //**********************************************************
    // Uncorrectable error status sources
    //**********************************************************
    // Map each error event onto its status bit
    always_comb begin
        ues_set                = '0;
        ues_set[UES_LINK_PROT] = link_protocol_error;
        ues_set[UES_SURPRISE]  = surprise_link_down_error
                                 && surprise_down_report_capable;
        ues_set[UES_POISONED]  = poisoned_tlp;
        ues_set[UES_FC_PROT]   = flow_credit_protocol_error;
        ues_set[UES_UNEXP_CPL] = unexpected_completion;
        ues_set[UES_RX_OVF]    = receive_overflow;
        ues_set[UES_MALFORMED] = malformed_tlp;
        ues_set[UES_ECRC]      = ecrc_error;
        ues_set[UES_UNSUP_REQ] = unsupported_request;
    end

    // Write one to clear, only on enabled bytes of writable bits
    assign ues_wclr = wr_ues
                      ? (cfg_wdata[UES_WIDTH-1:0]
                         & byte_mask[UES_WIDTH-1:0]
                         & UES_W1C_MASK[UES_WIDTH-1:0])
                      : '0;

    // Surprise down bit held clear while not capable
    always_comb begin
        ues_force               = '0;
        ues_force[UES_SURPRISE] = !surprise_down_report_capable;
    end

    assign ues_clr = ues_wclr | ues_force;

    //**********************************************************
    // Uncorrectable error status storage
    //**********************************************************
    // Bit 0 has no source; bits 14 and 15 have no flop at all
    sticky_w1c_bits #(
        .WIDTH (UES_WIDTH),
        .IMPL  (UES_W1C_MASK)
    ) u_ues (
        .clk     (clk),
        .nrst    (nrst),
        .set_vec (ues_set),
        .clr_vec (ues_clr),
        .stat_q  (ues_q)
    );

    // Pad up to a full word; upper bits are reserved
    assign ues_word = {{(32 - UES_WIDTH){1'b0}}, ues_q};

    assign uncorrectable_error_status = ues_word;

    //**********************************************************
    // Read data select
    //**********************************************************
    // Read mux over the selected target; unmapped reads give zero
    always_comb begin
        mux_word = DATA_RST;
        if (sel_addr) begin
            mux_word = addr_q;
        end else if (sel_cap) begin
            mux_word = cap_word;
        end else if (sel_ues) begin
            mux_word = ues_word;
        end
    end

    // Dead window accesses read zero; bytes follow the enables
    assign rdata_d = dead ? DATA_RST : (mux_word & byte_mask);

    //**********************************************************
    // Answer registers
    //**********************************************************
    // Read data is held until the next read is answered
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= DATA_RST;
        end else if (req_rd) begin
            rdata_q <= rdata_d;
        end
    end

    // Every request is answered one cycle later
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cfg_req;
        end
    end

    assign cfg_rdata = rdata_q;
    assign cfg_ack   = ack_q;

endmodule

// [verification/ecfg_regs_chk.sv]
/*
 * Concurrent checks on the ports of the configuration register block.
 * Assumes one clock, nrst as the only asynchronous reset.
 */
`timescale 1ns/1ps

module ecfg_regs_chk
    import ecfg_pkg::*;
(
    // Clock and resets
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        hot_reset,
    // Request port
    input wire logic        cfg_req,
    input wire logic        cfg_wr,
    input wire logic        cfg_sideband,
    input wire logic [11:2] cfg_addr,
    input wire logic [3:0]  cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic        cfg_ack,
    // Controls and events
    input wire logic        surprise_down_report_capable,
    input wire logic        link_protocol_error,
    input wire logic        surprise_link_down_error,
    input wire logic        poisoned_tlp,
    // State views
    input wire logic [31:0] indirect_config_address,
    input wire logic [31:0] uncorrectable_error_status
);
    //**********************************************************
    // Helpers and assertions
    //**********************************************************
    // Window hit and its current target
    wire logic        win = cfg_req && cfg_addr == OFF_DATA[11:2];
    wire logic [11:0] ptr = indirect_config_address[11:0];
    wire logic        dead = cfg_sideband || ptr == OFF_DATA;
    wire logic        cap = surprise_down_report_capable;
    wire logic [31:0] st = uncorrectable_error_status;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_ack_one_cycle: assert property (cfg_req |=> cfg_ack)
        else $error("ack missing after request");
    a_ack_has_cause: assert property (cfg_ack |-> $past(cfg_req))
        else $error("ack without request");
    a_cap_fixed: assert property (cfg_req && !cfg_wr
        && cfg_be[2:0] == 3'h7 && cfg_addr == OFF_CAP[11:2] |=>
        cfg_rdata[19:0] == {CAP_VER_VAL, CAP_ID_VAL})
        else $error("capability id or version wrong");
    a_self_zero: assert property (win && !cfg_wr && dead |=>
        cfg_rdata == 32'h0000_0000) else $error("dead window read not zero");
    a_self_drop: assert property (win && cfg_wr && dead
        && !hot_reset |=> $stable(indirect_config_address))
        else $error("dead window write took effect");
    a_win_to_addr: assert property (win && cfg_wr && !dead
        && !hot_reset && ptr == OFF_ADDR && cfg_be == 4'hF |=>
        indirect_config_address == ($past(cfg_wdata) & ADDR_RW_MASK))
        else $error("window write to address register lost");
    a_fixed_zero: assert property (
        (st & ~UES_W1C_MASK) == 32'h0000_0000 &&
        (indirect_config_address & ~ADDR_RW_MASK) == 32'h0000_0000)
        else $error("fixed zero bit set");
    a_surprise_gate: assert property (!cap [*2] |-> !st[UES_SURPRISE])
        else $error("surprise bit set while not capable");
    a_surprise_set: assert property (surprise_link_down_error && cap
        ##1 cap |-> st[UES_SURPRISE]) else $error("surprise bit not set");
    a_link_err_sets: assert property (link_protocol_error |=>
        st[UES_LINK_PROT]) else $error("link protocol bit not set");
    a_poison_sets: assert property (poisoned_tlp |=> st[UES_POISONED])
        else $error("poisoned bit not set");
    a_sticky_hot: assert property (hot_reset && !cfg_req && cap |=>
        (st & $past(st)) == $past(st))
        else $error("status lost on hot reset");

    c_window_read: cover property (win && !cfg_wr && !dead);
    c_hot_reset: cover property (hot_reset && st != 32'h0000_0000);
    c_surprise: cover property (surprise_link_down_error && cap);
endmodule

bind ecfg_regs ecfg_regs_chk i_chk (.clk(clk), .nrst(nrst),
    .hot_reset(hot_reset), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
    .cfg_sideband(cfg_sideband), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .surprise_down_report_capable(surprise_down_report_capable),
    .link_protocol_error(link_protocol_error),
    .surprise_link_down_error(surprise_link_down_error),
    .poisoned_tlp(poisoned_tlp),
    .indirect_config_address(indirect_config_address),
    .uncorrectable_error_status(uncorrectable_error_status));

// [verification/cfg_software.sv]
/*
 * Model of configuration software issuing one-dword requests.
 * Assumes it is called from one bench process just after a clock edge.
 */
`timescale 1ns/1ps

module cfg_software (
    // Clock
    input  wire logic        clk,
    // Request side
    output logic             cfg_req,
    output logic             cfg_wr,
    output logic             cfg_sideband,
    output logic      [11:2] cfg_addr,
    output logic      [3:0]  cfg_be,
    output logic      [31:0] cfg_wdata,
    // Answer side
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_ack
);
    initial begin
        {cfg_req, cfg_wr, cfg_sideband, cfg_addr, cfg_be, cfg_wdata} = '0;
    end

    // Drives a request over one taking edge; leaves it up for back to back
    task automatic access(input logic wr, input logic sb,
        input logic [11:0] a, input logic [3:0] be, input logic [31:0] d,
        output logic [31:0] rd, output logic ack);
        {cfg_req, cfg_wr, cfg_sideband} = {1'b1, wr, sb};
        {cfg_addr, cfg_be, cfg_wdata} = {a[11:2], be, d};
        @(posedge clk);
        #1;
        ack = cfg_ack;
        rd = cfg_rdata;
    endtask

    // Released lines stop showing the last request
    task automatic idle_bus();
        {cfg_req, cfg_wr, cfg_sideband} = {1'b0, ~cfg_wr, ~cfg_sideband};
        {cfg_addr, cfg_be, cfg_wdata} = ~{cfg_addr, cfg_be, cfg_wdata};
        @(posedge clk);
        #1;
    endtask
endmodule

// [verification/ext_cfg_window_and_aer_status_test.sv]
/*
 * Self-checking bench of the configuration register block with a
 * behavioural model. Assumes the checker is bound by its own file.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
    num_errors++; \
    $display("mismatch at %0t got %h exp %h", $time, got, exp); end end

module ext_cfg_window_and_aer_status_test;
    import ecfg_pkg::*;
    //**********************************************************
    // Signals, model state and helpers
    //**********************************************************
    logic        clk, nrst, hot_reset, lock, cap, cfg_req, cfg_wr, cfg_sb;
    logic        cfg_ack;
    logic [8:0]  ev;
    logic [11:2] cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, addr_view, ues_view;
    logic [31:0] seed = 32'h37f3_d2f5;
    logic [31:0] m_addr, m_cap, m_ues;
    logic [11:0] amap [6] = '{OFF_ADDR, OFF_DATA, OFF_CAP, OFF_UES,
                              12'h108, 12'h000};
    int          pos [9] = '{UES_LINK_PROT, UES_SURPRISE, UES_POISONED,
        UES_FC_PROT, UES_UNEXP_CPL, UES_RX_OVF, UES_MALFORMED, UES_ECRC,
        UES_UNSUP_REQ};
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    cfg_software i_sw (.clk(clk), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
        .cfg_sideband(cfg_sb), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));
    ecfg_regs i_dut (.clk(clk), .nrst(nrst), .hot_reset(hot_reset),
        .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_sideband(cfg_sb),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .cfg_write_lock(lock),
        .surprise_down_report_capable(cap), .link_protocol_error(ev[0]),
        .surprise_link_down_error(ev[1]), .poisoned_tlp(ev[2]),
        .flow_credit_protocol_error(ev[3]), .unexpected_completion(ev[4]),
        .receive_overflow(ev[5]), .malformed_tlp(ev[6]),
        .ecrc_error(ev[7]), .unsupported_request(ev[8]),
        .indirect_config_address(addr_view),
        .uncorrectable_error_status(ues_view));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0400_0007 : 32'h0);
        return seed;
    endfunction

    // Model register lookup; dead window cases land on an empty offset
    function automatic logic [31:0] reg_at(logic [11:0] a);
        case (a)
            OFF_ADDR: return m_addr;
            OFF_CAP:  return m_cap;
            OFF_UES:  return m_ues;
            default:  return 32'h0000_0000;
        endcase
    endfunction

    task automatic model_reset();
        m_addr = ADDR_RST;
        m_ues = UES_RST;
        m_cap = {NEXT_PTR_RST, CAP_VER_VAL, CAP_ID_VAL};
    endtask

    // One request through the software model, checked against the model
    task automatic op(logic wr, logic sb, logic [11:0] a, logic [3:0] be,
        logic [31:0] d);
        logic [31:0] rd, bm, evb, m;
        logic        ack;
        logic [11:0] t;
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        t = a;
        if (a == OFF_DATA) t = (sb || m_addr[11:0] == OFF_DATA) ? 12'h0 :
            m_addr[11:0];
        evb = 32'h0000_0000;
        for (int i = 0; i < 9; i++) if (ev[i]) evb[pos[i]] = 1'b1;
        if (!cap) evb[UES_SURPRISE] = 1'b0;
        m = (reg_at(t) & ~bm) | (d & bm);
        i_sw.access(wr, sb, a, be, d, rd, ack);
        `CHK(ack, 1'b1)
        if (!wr) `CHK(rd, reg_at(t) & bm)
        if (wr && t == OFF_ADDR) m_addr = m & ADDR_RW_MASK;
        if (wr && t == OFF_CAP && !lock) m_cap[31:20] = m[31:20];
        if (wr && t == OFF_UES) m_ues = m_ues & ~(d & bm & UES_W1C_MASK);
        m_ues = m_ues | evb;
        `CHK(addr_view, m_addr)
        `CHK(ues_view[15:0], m_ues[15:0])
        `CHK(ues_view[31:16], m_ues[31:16])
    endtask

    // Idle cycle that may drop the capability or pulse hot reset
    task automatic idle(logic c, logic h);
        {cap, hot_reset, ev} = {c, h, 9'h000};
        i_sw.idle_bus();
        hot_reset = 1'b0;
        if (!c) m_ues[UES_SURPRISE] = 1'b0;
        if (h) {m_addr, m_cap[31:20]} = {ADDR_RST, NEXT_PTR_RST};
        `CHK(ues_view, m_ues)
        `CHK(addr_view, m_addr)
    endtask

    // Random traffic; software clears status by writing ones
    task automatic run(int n);
        logic [31:0] r, q, d;
        for (int k = 0; k < n; k++) begin
            {r, q, d} = {lfsr(), lfsr(), lfsr()};
            if (r[19:17] == 3'h0) d[11:0] = amap[d[14:12] % 6];
            ev = r[8:0] & q[8:0] & d[20:12];
            lock = r[16] & q[16];
            op(r[9], r[10] & r[11], amap[q[26:24] % 6], r[15:12], d);
            if (q[13:11] == 3'h0) idle(q[20] | q[21], q[22] & q[23]);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end

    //**********************************************************
    // Main sequence: reset values, traffic, mid-run reset, traffic
    //**********************************************************
    initial begin
        {nrst, hot_reset, lock, cap, ev} = {3'b000, 1'b1, 9'h000};
        model_reset();
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        foreach (amap[i]) op(1'b0, 1'b0, amap[i], 4'hF, 32'h0);
        // Window aimed at the address register, then at itself
        op(1'b1, 1'b0, OFF_ADDR, 4'hF, 32'h0000_00F8);
        op(1'b1, 1'b0, OFF_DATA, 4'hF, 32'hFFFF_F104);
        op(1'b0, 1'b0, OFF_DATA, 4'hF, 32'h0000_0000);
        op(1'b1, 1'b0, OFF_ADDR, 4'h3, 32'h0000_00FC);
        op(1'b1, 1'b0, OFF_DATA, 4'hF, 32'h0000_0104);
        op(1'b0, 1'b1, OFF_DATA, 4'hF, 32'h0000_0000);
        run(700);
        idle(1'b1, 1'b0);
        nrst = 1'b0;
        model_reset();
        @(posedge clk);
        #1 nrst = 1'b1;
        run(300);
        test_done();
    end
endmodule
